// [hdl/pcfs_unit.sv]
// Purpose: Program counter with holding latches, vectoring and fast stack
// Assumes: Core strobes are one-cycle pulses on clk_sys
// Notes:   Registers reached over AXI4-Lite
//
// Notes on behaviour
// - Counter is 21 bits, addresses bytes.
// - Low byte readable and writable by software.
// - Low byte writes set bits 15..8 only via middle latch.
// - Low byte writes set bits 20..16 only via upper latch.
// - Counter bit zero always reads zero.
// - Sequential fetch adds two.
// - Jumps and calls bypass the holding latches.
// - Low byte write copies latches into counter.
// - Low byte read copies counter into latches.
// - One-deep hidden shadow of status, working, bank.
// - Vectoring saves status, working, bank.
// - Fast return restores status, working, bank.
// - Fast return only for high-priority frames.
// - Enabled interrupt wake pushes counter, bumps pointer.
// - Enabled interrupt wake loads the vector.
`default_nettype none
module pcfs_unit
   import pcfs_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output logic               s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output logic               s_wready,
   output logic     [1:0]     s_bresp,
   output logic               s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [AW-1:0] s_araddr,
   input  wire logic          s_arvalid,
   output logic               s_arready,
   output logic     [31:0]    s_rdata,
   output logic     [1:0]     s_rresp,
   output logic               s_rvalid,
   input  wire logic          s_rready,
   input  wire logic          fetch_adv,
   input  wire logic          jump_load,
   input  wire logic [20:0]   jump_addr,
   input  wire logic          irq_vector,
   input  wire logic          wake_irq,
   input  wire logic          irq_high,
   input  wire logic          fast_ret,
   input  wire logic [7:0]    status_in,
   input  wire logic [7:0]    working_in,
   input  wire logic [7:0]    bank_in,
   output logic     [20:0]    program_counter,
   output logic     [7:0]     stack_top_low,
   output logic     [7:0]     stack_top_high,
   output logic     [4:0]     stack_top_upper,
   output logic     [4:0]     return_stack_pointer,
   output logic     [7:0]     status_rest,
   output logic     [7:0]     working_rest,
   output logic     [7:0]     bank_rest,
   output logic               restore_pulse,
   output logic               vector_taken
);
   // ****************************************
   // State
   // ****************************************
   logic [20:0]   pc_ff;          // Program counter
   logic [20:0]   nxt_pc;         // Next program counter
   logic [7:0]    mid_latch_ff;   // Middle holding latch
   logic [4:0]    upr_latch_ff;   // Upper holding latch
   logic [7:0]    nxt_mid;        // Next middle latch
   logic [4:0]    nxt_upr;        // Next upper latch
   logic [20:0]   tos_ff;         // Top of return stack
   logic [4:0]    sp_ff;          // Return stack pointer
   logic          en_hi_ff;       // High global enable
   logic          en_lo_ff;       // Low global enable
   logic          vec_ff;         // Vector strobe out

   // ****************************************
   // Register decode
   // ****************************************
   pcfs_reg_if    rg ();          // Bus to core strobes
   logic          wr_low;         // Write counter low byte
   logic          wr_mid;         // Write middle latch
   logic          wr_upr;         // Write upper latch
   logic          wr_ctrl;        // Write enables
   logic          rd_low;         // Read counter low byte
   logic [31:0]   rd_mux;         // Read data select
   logic          any_en;         // Either global enable set
   logic          vec_go;         // Take an interrupt vector
   logic [20:0]   vec_addr;       // Selected vector
   logic [20:0]   pc_inc;         // Counter plus one word
   logic [20:0]   pc_from_low;    // Counter built from latches
   logic [4:0]    sp_inc;         // Pointer plus one

   // Bus slave
   pcfs_axil u_axil
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .rg        (rg.bus)
   );

   // Address decode
   assign wr_low  = rg.wr_en & (rg.wr_addr == OFS_LOW);
   assign wr_mid  = rg.wr_en & (rg.wr_addr == OFS_MID);
   assign wr_upr  = rg.wr_en & (rg.wr_addr == OFS_UPR);
   assign wr_ctrl = rg.wr_en & (rg.wr_addr == OFS_CTRL);
   assign rd_low  = rg.rd_en & (rg.rd_addr == OFS_LOW);

   // Mapped addresses; status is read only
   assign rg.wr_hit = (rg.wr_addr == OFS_LOW) | (rg.wr_addr == OFS_MID)
                    | (rg.wr_addr == OFS_UPR) | (rg.wr_addr == OFS_CTRL);
   assign rg.rd_hit = (rg.rd_addr inside {OFS_LOW, OFS_MID, OFS_UPR, OFS_CTRL, OFS_STAT});

   // ****************************************
   // Read data
   // ****************************************
   // Counter low byte is visible; middle and upper bytes read back from the holding latches
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (rg.rd_addr)
         OFS_LOW:  rd_mux = {24'h000000, pc_ff[7:1], 1'b0};
         OFS_MID:  rd_mux = {24'h000000, mid_latch_ff};
         OFS_UPR:  rd_mux = {27'h0000000, upr_latch_ff};
         OFS_CTRL: rd_mux = {30'h00000000, en_lo_ff, en_hi_ff};
         OFS_STAT: rd_mux = {27'h0000000, sp_ff};
         default:  rd_mux = 32'h00000000;
      endcase
   end
   assign rg.rd_data = rd_mux;

   // ****************************************
   // Counter arithmetic
   // ****************************************
   assign any_en      = en_hi_ff | en_lo_ff;
   assign vec_go      = irq_vector | (wake_irq & any_en);
   assign vec_addr    = irq_high ? VEC_HIGH : VEC_LOW;
   assign pc_inc      = pc_ff + PC_STEP;
   assign sp_inc      = sp_ff + SP_STEP;
   // Upper bits come only from the holding latches
   assign pc_from_low = {upr_latch_ff, mid_latch_ff,
                         rg.wr_data[7:1], 1'b0};

   // Next counter: vector, jump, low-byte write, then sequential step
   always_comb
   begin
      nxt_pc = pc_ff;
      if (vec_go)
         nxt_pc = vec_addr;
      else if (jump_load)
         nxt_pc = {jump_addr[20:1], 1'b0};
      else if (wr_low)
         nxt_pc = pc_from_low;
      else if (fetch_adv)
         nxt_pc = pc_inc;
   end

   // Next latches: a low-byte read refreshes both, else software writes
   always_comb
   begin
      nxt_mid = mid_latch_ff;
      nxt_upr = upr_latch_ff;
      if (rd_low)
      begin
         nxt_mid = pc_ff[15:8];
         nxt_upr = pc_ff[20:16];
      end
      else
      begin
         if (wr_mid)
            nxt_mid = rg.wr_data[7:0];
         if (wr_upr)
            nxt_upr = rg.wr_data[UP_W-1:0];
      end
   end

   // ****************************************
   // Counter and latch registers
   // ****************************************
   // Counter update; bit zero is never stored as one
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         pc_ff <= PC_RST;
      else if (ce)
         pc_ff <= {nxt_pc[20:1], 1'b0};
   end

   // Holding latches
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         mid_latch_ff <= 8'h00;
         upr_latch_ff <= 5'h00;
      end
      else if (ce)
      begin
         mid_latch_ff <= nxt_mid;
         upr_latch_ff <= nxt_upr;
      end
   end

   // Global enables held for wake decisions
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         en_hi_ff <= 1'b0;
         en_lo_ff <= 1'b0;
      end
      else if (ce && wr_ctrl)
      begin
         en_hi_ff <= rg.wr_data[CTRL_HI];
         en_lo_ff <= rg.wr_data[CTRL_LO];
      end
   end

   // ****************************************
   // Return stack push on vectoring
   // ****************************************
   // Current counter goes to top of stack, pointer moves on
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         tos_ff <= PC_RST;
         sp_ff  <= SP_RST;
         vec_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (vec_go)
         begin
            tos_ff <= pc_ff;
            sp_ff  <= sp_inc;
         end
         vec_ff <= vec_go;
      end
   end

   // ****************************************
   // Shadow store
   // ****************************************
   pcfs_shadow u_shadow
   (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .ce            (ce),
      .save          (vec_go),
      .save_high     (irq_high),
      .fast_ret      (fast_ret),
      .status_in     (status_in),
      .working_in    (working_in),
      .bank_in       (bank_in),
      .status_rest   (status_rest),
      .working_rest  (working_rest),
      .bank_rest     (bank_rest),
      .restore_pulse (restore_pulse)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign program_counter      = pc_ff;
   assign stack_top_low        = tos_ff[7:0];
   assign stack_top_high       = tos_ff[15:8];
   assign stack_top_upper      = tos_ff[20:16];
   assign return_stack_pointer = sp_ff;
   assign vector_taken         = vec_ff;
endmodule
`default_nettype wire

// [inc/pcfs_pkg.sv]
// Purpose: Shared constants for the program counter and fast stack unit
// Assumes: 32-bit AXI4-Lite register bus, byte-addressed program memory
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none
package pcfs_pkg;
   // ****************************************
   // Program counter geometry
   // ****************************************
   localparam int          PC_W      = 21;           // Counter width
   localparam int          SP_W      = 5;            // Stack pointer width
   localparam int          UP_W      = 5;            // Upper byte width
   localparam logic [20:0] PC_RST    = 21'h000000;   // Start address
   localparam logic [20:0] PC_STEP   = 21'h000002;   // One instruction word
   localparam logic [20:0] VEC_HIGH  = 21'h000008;   // High priority vector
   localparam logic [20:0] VEC_LOW   = 21'h000018;   // Low priority vector
   localparam logic [4:0]  SP_STEP   = 5'h01;        // Stack pointer step
   localparam logic [4:0]  SP_RST    = 5'h00;        // Stack pointer reset
   // ****************************************
   // Register map
   // ****************************************
   localparam int          AW        = 8;            // Bus address width
   localparam logic [7:0]  OFS_LOW   = 8'h00;        // Counter low byte
   localparam logic [7:0]  OFS_MID   = 8'h04;        // Middle holding latch
   localparam logic [7:0]  OFS_UPR   = 8'h08;        // Upper holding latch
   localparam logic [7:0]  OFS_CTRL  = 8'h0c;        // Interrupt enables
   localparam logic [7:0]  OFS_STAT  = 8'h10;        // Stack pointer view
   localparam int          CTRL_HI   = 0;            // High enable bit
   localparam int          CTRL_LO   = 1;            // Low enable bit
   localparam logic [1:0]  RESP_OK   = 2'h0;         // Bus okay
   localparam logic [1:0]  RESP_ERR  = 2'h2;         // Bus slave error
endpackage
`default_nettype wire

// [inc/pcfs_reg_if.sv]
// Purpose: Register access strobes between bus slave and counter core
// Assumes: One write and one read strobe, each one cycle long
// Notes:   Read data is combinational from the core side
`default_nettype none
interface pcfs_reg_if;
   import pcfs_pkg::*;
   logic          wr_en;    // Write strobe
   logic [AW-1:0] wr_addr;  // Write byte address
   logic [31:0]   wr_data;  // Write data
   logic          rd_en;    // Read strobe
   logic [AW-1:0] rd_addr;  // Read byte address
   logic [31:0]   rd_data;  // Read data, same cycle
   logic          rd_hit;   // Read address is mapped
   logic          wr_hit;   // Write address is mapped
   modport bus  (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 input rd_data, rd_hit, wr_hit);
   modport core (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 output rd_data, rd_hit, wr_hit);
endinterface
`default_nettype wire

// [hdl/pcfs_shadow.sv]
// Purpose: One-deep shadow store for status, working and bank registers
// Assumes: Load and restore strobes come from the counter core
// Notes:   Not visible on the register bus
`default_nettype none
module pcfs_shadow
   import pcfs_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       save,
   input  wire logic       save_high,
   input  wire logic       fast_ret,
   input  wire logic [7:0] status_in,
   input  wire logic [7:0] working_in,
   input  wire logic [7:0] bank_in,
   output logic     [7:0]  status_rest,
   output logic     [7:0]  working_rest,
   output logic     [7:0]  bank_rest,
   output logic            restore_pulse
);
   logic [23:0] store_ff;     // Saved status, working, bank
   logic        high_ff;      // Saved frame came from high priority
   logic [23:0] out_ff;       // Restored values
   logic        pulse_ff;     // Restore strobe
   logic        do_rest;      // Fast return allowed

   // Fast return restores only a high-priority frame
   assign do_rest = fast_ret & high_ff & ~save;
   assign status_rest   = out_ff[23:16];
   assign working_rest  = out_ff[15:8];
   assign bank_rest     = out_ff[7:0];
   assign restore_pulse = pulse_ff;

   // Store, then replay on fast return
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         store_ff <= 24'h000000;
         high_ff  <= 1'b0;
         out_ff   <= 24'h000000;
         pulse_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (save)
         begin
            store_ff <= {status_in, working_in, bank_in};
            high_ff  <= save_high;
         end
         if (do_rest)
            out_ff <= store_ff;
         pulse_ff <= do_rest;
      end
   end
endmodule
`default_nettype wire

// [hdl/pcfs_axil.sv]
// Purpose: AXI4-Lite slave that turns bus transfers into register strobes
// Assumes: One write and one read outstanding at a time
// Notes:   Unmapped addresses answer with a slave error
`default_nettype none
module pcfs_axil
   import pcfs_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          ce,
   input  wire logic [AW-1:0] s_awaddr,
   input  wire logic          s_awvalid,
   output logic               s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output logic               s_wready,
   output logic     [1:0]     s_bresp,
   output logic               s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [AW-1:0] s_araddr,
   input  wire logic          s_arvalid,
   output logic               s_arready,
   output logic     [31:0]    s_rdata,
   output logic     [1:0]     s_rresp,
   output logic               s_rvalid,
   input  wire logic          s_rready,
   pcfs_reg_if.bus            rg
);
   // ****************************************
   // Write channel
   // ****************************************
   typedef enum logic [1:0] {W_COLLECT = 2'b01, W_RESP = 2'b10} pcfs_wst_e;
   pcfs_wst_e     wst_ff;       // Write state
   pcfs_wst_e     nxt_wst;      // Next write state
   logic          aw_ok_ff;     // Address held
   logic          w_ok_ff;      // Data held
   logic [AW-1:0] awaddr_ff;    // Held address
   logic [31:0]   wdata_ff;     // Held data
   logic          wlane_ff;     // Low byte lane enabled
   logic [1:0]    bresp_ff;     // Write answer
   logic          aw_take;      // Address handshake
   logic          w_take;       // Data handshake
   logic          wr_go;        // Both halves present
   logic          ar_take;      // Read handshake
   logic          rvalid_ff;    // Read answer pending
   logic [31:0]   rdata_ff;     // Read data
   logic [1:0]    rresp_ff;     // Read answer code

   assign s_awready = (wst_ff == W_COLLECT) & ~aw_ok_ff;
   assign s_wready  = (wst_ff == W_COLLECT) & ~w_ok_ff;
   assign aw_take   = s_awvalid & s_awready & ce;
   assign w_take    = s_wvalid & s_wready & ce;
   assign wr_go     = (wst_ff == W_COLLECT) & aw_ok_ff & w_ok_ff & ce;
   assign s_bvalid  = (wst_ff == W_RESP);
   assign s_bresp   = bresp_ff;
   assign rg.wr_en  = wr_go & wlane_ff;
   assign rg.wr_addr = awaddr_ff;
   assign rg.wr_data = wdata_ff;

   // Next write state
   always_comb
   begin
      nxt_wst = wst_ff;
      case (wst_ff)
         W_COLLECT: if (wr_go) nxt_wst = W_RESP;
         W_RESP:    if (s_bready) nxt_wst = W_COLLECT;
         default:   nxt_wst = W_COLLECT;
      endcase
   end

   // Hold address and data until both arrived
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wst_ff    <= W_COLLECT;
         aw_ok_ff  <= 1'b0;
         w_ok_ff   <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff  <= 32'h00000000;
         wlane_ff  <= 1'b0;
         bresp_ff  <= RESP_OK;
      end
      else if (ce)
      begin
         wst_ff <= nxt_wst;
         if (aw_take)
         begin
            awaddr_ff <= s_awaddr;
            aw_ok_ff  <= 1'b1;
         end
         if (w_take)
         begin
            wdata_ff <= s_wdata;
            wlane_ff <= s_wstrb[0];
            w_ok_ff  <= 1'b1;
         end
         if (wr_go)
         begin
            aw_ok_ff <= 1'b0;
            w_ok_ff  <= 1'b0;
            bresp_ff <= rg.wr_hit ? RESP_OK : RESP_ERR;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   assign s_arready  = ~rvalid_ff;
   assign ar_take    = s_arvalid & s_arready & ce;
   assign rg.rd_en   = ar_take;
   assign rg.rd_addr = s_araddr;
   assign s_rvalid   = rvalid_ff;
   assign s_rdata    = rdata_ff;
   assign s_rresp    = rresp_ff;

   // Capture data on address handshake, answer next cycle
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= RESP_OK;
      end
      else if (ce)
      begin
         if (ar_take)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rg.rd_data;
            rresp_ff  <= rg.rd_hit ? RESP_OK : RESP_ERR;
         end
         else if (s_rready)
            rvalid_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [test/pcfs_unit_asserts.sv]
// Purpose: Port checks of the program counter unit
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to every pcfs_unit instance
`default_nettype none
module pcfs_unit_asserts
   import pcfs_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        fetch_adv,
   input wire logic        jump_load,
   input wire logic [20:0] jump_addr,
   input wire logic        irq_vector,
   input wire logic        wake_irq,
   input wire logic        irq_high,
   input wire logic        fast_ret,
   input wire logic        s_bvalid,
   input wire logic        s_arvalid,
   input wire logic        s_arready,
   input wire logic        s_rvalid,
   input wire logic [20:0] program_counter,
   input wire logic [7:0]  stack_top_low,
   input wire logic [4:0]  return_stack_pointer,
   input wire logic        restore_pulse
);
   // ***********************************
   // Checks on the counter and stack
   // ***********************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   pc_align_a: assert property (program_counter[0] == 1'b0)
      else $error("counter odd");
   // A write to the low byte may land in the same cycle as a fetch
   fetch_step_a: assert property (fetch_adv && ce && !jump_load && !irq_vector && !wake_irq
      |=> $rose(s_bvalid) || program_counter == $past(program_counter) + PC_STEP)
      else $error("fetch step wrong");
   jump_ld_a: assert property (jump_load && ce && !irq_vector && !wake_irq
      |=> (program_counter ^ $past(jump_addr)) <= 21'h000001) else $error("jump wrong");
   vec_addr_a: assert property (irq_vector && ce
      |=> program_counter == ($past(irq_high) ? VEC_HIGH : VEC_LOW)) else $error("vector wrong");
   sp_bump_a: assert property (irq_vector && ce
      |=> return_stack_pointer == $past(return_stack_pointer) + SP_STEP) else $error("push ptr");
   push_pc_a: assert property (irq_vector && ce
      |=> stack_top_low == 8'($past(program_counter))) else $error("pushed pc wrong");
   sp_hold_a: assert property (!irq_vector && !wake_irq
      |=> $stable(return_stack_pointer)) else $error("pointer moved");
   restore_a: assert property (restore_pulse |-> $past(fast_ret))
      else $error("stray restore");
   rd_answer_a: assert property (s_arvalid && s_arready && ce |=> s_rvalid)
      else $error("read late");
   cover property (irq_vector && irq_high);
   cover property (restore_pulse);
   cover property (s_arvalid && s_arready);
endmodule
bind pcfs_unit pcfs_unit_asserts i_chk (.*);
`default_nettype wire

// [test/pcfs_core_model.sv]
// Purpose: Fetch and execute side that strobes the counter unit
// Assumes: Strobes last one clock; irq_high is a level
// Notes:   Jump address shows its inverse once released
`default_nettype none
module pcfs_core_model
(
   input  wire logic       clk_sys,
   output logic            fetch_adv,
   output logic            jump_load,
   output logic [20:0]     jump_addr,
   output logic            irq_vector,
   output logic            wake_irq,
   output logic            irq_high,
   output logic            fast_ret,
   output logic [7:0]      status_in,
   output logic [7:0]      working_in,
   output logic [7:0]      bank_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***********************************
   // One operation per call
   // ***********************************
   initial
   begin
      {fetch_adv, jump_load, irq_vector, wake_irq, fast_ret, irq_high} = 6'h00;
      {jump_addr, status_in, working_in, bank_in} = '0;
   end
   // Op: 0 fetch, 1 jump, 2 vector, 3 wake, 4 fast return
   task automatic issue(input logic [2:0] op, input logic hi, input logic [23:0] d);
      @(posedge clk_sys);
      jump_addr <= d[20:0];
      irq_high <= hi;
      {status_in, working_in, bank_in} <= d;
      fetch_adv <= (op == 3'h0);
      jump_load <= (op == 3'h1);
      irq_vector <= (op == 3'h2);
      wake_irq <= (op == 3'h3);
      fast_ret <= (op == 3'h4);
      @(posedge clk_sys);
      jump_addr <= ~d[20:0];
      {fetch_adv, jump_load, irq_vector, wake_irq, fast_ret} <= 5'h00;
   endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench of the program counter unit
// Assumes: Bus answers are checked in order from a queue
// Notes:   Clock enable held high
`default_nettype none
`define CHK(n, e, g) begin logic [33:0] t; t = (e); num_checks++; \
   if ((g) !== t) begin error_cnt++; $display("ERROR %s exp %h got %h", n, t, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pcfs_pkg::*;
   logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
   logic [7:0]  s_awaddr = '0, s_araddr = '0;
   logic [31:0] s_wdata = '0, s_rdata, r;
   logic [3:0]  s_wstrb = '0;
   logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, restore_pulse, vector_taken;
   logic [1:0]  s_bresp, s_rresp;
   logic        fetch_adv, jump_load, irq_vector, wake_irq, irq_high, fast_ret;
   logic [20:0] jump_addr, program_counter, p;
   logic [7:0]  status_in, working_in, bank_in, status_rest, working_rest, bank_rest;
   logic [7:0]  stack_top_low, stack_top_high, lat;
   logic [4:0]  stack_top_upper, return_stack_pointer, sp = '0;
   logic [23:0] sv;
   logic [33:0] exq[$];
   int          seed = 25, error_cnt = 0, num_checks = 0;
   pcfs_unit i_dut (.*);
   pcfs_core_model i_core (.*);
   always #10 clk_sys = ~clk_sys;
   // ***********************************
   // Bus master and answer checker
   // ***********************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] rsp);
      exq.push_back({rsp, 32'h0});
      @(posedge clk_sys);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= s;
      {s_awvalid, s_wvalid, s_bready} <= 3'h7;
      do
      begin
         @(posedge clk_sys);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end
      while ((s_awvalid && !s_awready) || (s_wvalid && !s_wready));
      do @(posedge clk_sys); while (!s_bvalid);
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      exq.push_back({rsp, d});
      @(posedge clk_sys);
      s_araddr <= a;
      {s_arvalid, s_rready} <= 2'h3;
      do @(posedge clk_sys); while (!s_arready);
      s_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_rvalid);
      s_rready <= 1'b0;
   endtask
   // Oldest note is compared with each answer seen
   always @(posedge clk_sys)
   begin
      if (s_bvalid && s_bready) `CHK("write answer", exq.pop_front(), {s_bresp, 32'h0})
      if (s_rvalid && s_rready) `CHK("read answer", exq.pop_front(), {s_rresp, s_rdata})
   end
   task automatic report_and_stop;
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #80000;
      error_cnt++;
      report_and_stop;
   end
   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_LOW, 32'h0, RESP_OK);
      r = $random(seed);
      lat = r[7:0];
      wr(OFS_MID, {24'h0, r[7:0]}, 4'hf, RESP_OK);
      wr(OFS_UPR, {27'h0, r[12:8]}, 4'hf, RESP_OK);
      wr(OFS_LOW, {24'h0, r[23:16]}, 4'hf, RESP_OK);
      p = {r[12:8], r[7:0], r[23:17], 1'b0};
      `CHK("pc load", p, program_counter)
      wr(OFS_LOW, 32'hff, 4'h0, RESP_OK);
      `CHK("pc no strobe", p, program_counter)
      repeat (3)
      begin
         i_core.issue(3'h0, 1'b0, 24'h0);
         @(negedge clk_sys);
         p = p + PC_STEP;
         `CHK("pc fetch", p, program_counter)
      end
      r = $random(seed);
      i_core.issue(3'h1, 1'b0, r[23:0]);
      @(negedge clk_sys);
      p = {r[20:1], 1'b0};
      `CHK("pc jump", p, program_counter)
      rd(OFS_MID, {24'h0, lat}, RESP_OK);
      rd(OFS_LOW, {24'h0, p[7:0]}, RESP_OK);
      rd(OFS_MID, {24'h0, p[15:8]}, RESP_OK);
      rd(OFS_UPR, {27'h0, p[20:16]}, RESP_OK);
      for (int h = 1; h >= 0; h--)
      begin
         r = $random(seed);
         if (h == 1) sv = r[23:0];
         i_core.issue(3'h2, h[0], r[23:0]);
         @(negedge clk_sys);
         sp = sp + SP_STEP;
         `CHK("pushed pc", p, {stack_top_upper, stack_top_high, stack_top_low})
         `CHK("stack ptr", sp, return_stack_pointer)
         p = h ? VEC_HIGH : VEC_LOW;
         `CHK("vector", p, program_counter)
         `CHK("vector pulse", 1'b1, vector_taken)
         i_core.issue(3'h4, h[0], 24'h0);
         @(negedge clk_sys);
         `CHK("restore pulse", h[0], restore_pulse)
         `CHK("restored", sv, {status_rest, working_rest, bank_rest})
      end
      i_core.issue(3'h3, 1'b1, 24'h0);
      @(negedge clk_sys);
      `CHK("wake masked", p, program_counter)
      wr(OFS_CTRL, 32'h2, 4'hf, RESP_OK);
      i_core.issue(3'h3, 1'b1, 24'h0);
      @(negedge clk_sys);
      sp = sp + SP_STEP;
      `CHK("wake vector", VEC_HIGH, program_counter)
      rd(OFS_STAT, {27'h0, sp}, RESP_OK);
      rd(8'h14, 32'h0, RESP_ERR);
      wr(8'h20, 32'h1, 4'hf, RESP_ERR);
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      `CHK("pc reset", PC_RST, program_counter)
      rd(OFS_UPR, 32'h0, RESP_OK);
      report_and_stop;
   end
endmodule
`default_nettype wire
